// file: rtl/sarseq_pkg.sv
// Purpose: shared constants and types for the conversion sequencer
// Assumes: one system clock of 10 MHz; pin clock nominally 4 MHz
// Notes: edge counts are falling edges of the pin clock
package sarseq_pkg;

  // -------------------------------------------------------------------
  // widths and clock division
  // -------------------------------------------------------------------
  localparam int RESULT_BITS = 8;
  localparam int PIN_DIVIDE = 2;
  localparam int INT_CYCLES_PER_CONV = 10;
  localparam int PIN_EDGES_PER_CONV = INT_CYCLES_PER_CONV * PIN_DIVIDE;
  localparam int EDGE_CNT_W = 5;

  // -------------------------------------------------------------------
  // sequence points, counted in pin clock falling edges from start
  // -------------------------------------------------------------------
  localparam logic [EDGE_CNT_W-1:0] EDGE_CLEAR = 5'h01;
  localparam logic [EDGE_CNT_W-1:0] EDGE_HOLD = 5'h03;
  localparam logic [EDGE_CNT_W-1:0] EDGE_FIRST_DECIDE = 5'h05;
  localparam logic [EDGE_CNT_W-1:0] EDGE_LAST_DECIDE = 5'h13;
  localparam logic [EDGE_CNT_W-1:0] EDGE_DONE = 5'h14;

  // -------------------------------------------------------------------
  // reset values and the first trial code
  // -------------------------------------------------------------------
  localparam logic [RESULT_BITS-1:0] RESULT_RESET = 8'h00;
  localparam logic [RESULT_BITS-1:0] TRIAL_MSB = 8'h80;
  localparam logic [EDGE_CNT_W-1:0] EDGE_CNT_RESET = 5'h00;

  // -------------------------------------------------------------------
  // timing (nominal pin clock and conversion time)
  // -------------------------------------------------------------------
  localparam int SYS_PERIOD_NS = 100;
  localparam int PIN_CLK_KHZ = 4000;
  localparam int CONV_TIME_NS = 5000;
  localparam int CONV_SYS_CYCLES = CONV_TIME_NS / SYS_PERIOD_NS;

  // -------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b01,
    SQ_CONV = 2'b10
  } sarseq_state_t;

  // data bus drive towards the host
  typedef struct packed {
    logic [RESULT_BITS-1:0] data;
    logic oe;
  } sarseq_bus_t;

endpackage

// file: rtl/sarseq_sync.sv
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: input is asynchronous to clk_sys
// Notes: only the second stage may be read outside
`timescale 1ns/1ps
module sarseq_sync
#(
  parameter logic RESET_VAL = 1'b0
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // level in and out
  input wire logic pin,
  output logic level
);

  logic meta_q;

  // -------------------------------------------------------------------
  // two stage capture
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= RESET_VAL;
      level <= RESET_VAL;
    end
    else
    begin
      meta_q <= pin;
      level <= meta_q;
    end
  end

endmodule

// file: rtl/sarseq_top.sv
// Purpose: clocking and conversion sequencing of an 8-bit APPROXIMATION_REGISTER converter
// Assumes: pin clock, strobes and comparator arrive asynchronously
// Notes: comparator decides analog_input against the trial code
`timescale 1ns/1ps
module sarseq_top
  import sarseq_pkg::*;
#(
  parameter int RBITS = RESULT_BITS
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // clock pin and its source
  input wire logic conv_clk_pin,
  input wire logic ext_clk_sel,
  output logic osc_run_q,
  output logic div_clk_q,
  // host strobes
  input wire logic cs_n,
  input wire logic rd_n,
  output logic busy_n_q,
  // host data bus
  output sarseq_bus_t bus_q,
  // analog side
  input wire logic comp_in,
  output logic hold_q,
  output logic [RBITS-1:0] approximation_register_q,
  output logic [RBITS-1:0] result_q
);

  // -------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------
  sarseq_state_t state_q;
  logic clk_s;
  logic ext_s;
  logic clk_prev_q;
  logic clk_fall;
  logic cs_n_s;
  logic rd_n_s;
  logic comp_s;
  logic req;
  logic req_prev_q;
  logic start;
  logic skip_q;
  logic [EDGE_CNT_W-1:0] edge_q;
  logic [EDGE_CNT_W-1:0] edge_d;
  logic [RBITS-1:0] mask_q;
  logic decide;

  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  sarseq_sync #(.RESET_VAL(1'b0)) u_sync_clk
    (.clk_sys(clk_sys), .rst(rst), .pin(conv_clk_pin), .level(clk_s));
  sarseq_sync #(.RESET_VAL(1'b1)) u_sync_cs
    (.clk_sys(clk_sys), .rst(rst), .pin(cs_n), .level(cs_n_s));
  sarseq_sync #(.RESET_VAL(1'b1)) u_sync_rd
    (.clk_sys(clk_sys), .rst(rst), .pin(rd_n), .level(rd_n_s));
  sarseq_sync #(.RESET_VAL(1'b0)) u_sync_comp
    (.clk_sys(clk_sys), .rst(rst), .pin(comp_in), .level(comp_s));
  // source select is a pin too; reset picks the external clock
  sarseq_sync #(.RESET_VAL(1'b1)) u_sync_sel
    (.clk_sys(clk_sys), .rst(rst), .pin(ext_clk_sel), .level(ext_s));

  // -------------------------------------------------------------------
  // edge and request detection
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      clk_prev_q <= 1'b0;
      req_prev_q <= 1'b0;
    end
    else
    begin
      clk_prev_q <= clk_s;
      req_prev_q <= req;
    end
  end

  // falling pin edge; idle edges only end the no-restart window
  assign clk_fall = clk_prev_q & ~clk_s;
  // both strobes low together, taken on the combined falling edge
  assign req = ~cs_n_s & ~rd_n_s;
  assign start = req & ~req_prev_q & (state_q == SQ_IDLE) & ~skip_q;
  assign edge_d = edge_q + 5'h01;
  // odd edges from the fifth on carry one bit decision each
  assign decide = clk_fall & (state_q == SQ_CONV) & edge_d[0]
    & (edge_d >= EDGE_FIRST_DECIDE) & (edge_d <= EDGE_LAST_DECIDE);

  // -------------------------------------------------------------------
  // sequencer state and edge counter
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q <= SQ_IDLE;
      edge_q <= EDGE_CNT_RESET;
    end
    else
    begin
      case (state_q)
        SQ_IDLE:
        begin
          if (start)
          begin
            state_q <= SQ_CONV;
            edge_q <= EDGE_CNT_RESET;
          end
        end
        SQ_CONV:
        begin
          if (clk_fall)
          begin
            edge_q <= edge_d;
            if (edge_d == EDGE_DONE)
            begin
              state_q <= SQ_IDLE;
            end
          end
        end
        default:
        begin
          state_q <= SQ_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // divided internal clock, running only during a conversion
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      div_clk_q <= 1'b0;
    end
    else if (state_q != SQ_CONV || (clk_fall && edge_d == EDGE_DONE))
    begin
      div_clk_q <= 1'b0;
    end
    else if (clk_fall)
    begin
      div_clk_q <= ~div_clk_q;
    end
  end

  // -------------------------------------------------------------------
  // own oscillator run enable
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      osc_run_q <= 1'b0;
    end
    else if (ext_s)
    begin
      osc_run_q <= 1'b0;
    end
    else if (start)
    begin
      osc_run_q <= 1'b1;
    end
    else if (state_q == SQ_CONV && clk_fall && edge_d == EDGE_DONE)
    begin
      osc_run_q <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // busy flag and no-restart window after completion
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      busy_n_q <= 1'b1;
      skip_q <= 1'b0;
    end
    else if (start)
    begin
      busy_n_q <= 1'b0;
    end
    else if (state_q == SQ_CONV && clk_fall && edge_d == EDGE_DONE)
    begin
      busy_n_q <= 1'b1;
      skip_q <= ext_s; // window only follows an external clock
    end
    else if (clk_fall || (state_q == SQ_IDLE && ext_s == 1'b0
      && req & ~req_prev_q))
    begin
      skip_q <= 1'b0; // window ends at next falling pin edge, or at a strobe while ext_s is low
    end
  end

  // -------------------------------------------------------------------
  // track and hold control
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      hold_q <= 1'b0;
    end
    else if (state_q == SQ_CONV && clk_fall && edge_d == EDGE_HOLD)
    begin
      hold_q <= 1'b1;
    end
    else if (state_q == SQ_CONV && clk_fall && edge_d == EDGE_DONE)
    begin
      hold_q <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // successive approximation: clear, trial, decide
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      approximation_register_q <= RESULT_RESET;
      mask_q <= RESULT_RESET;
    end
    else if (state_q == SQ_CONV && clk_fall && edge_d == EDGE_CLEAR)
    begin
      approximation_register_q <= RESULT_RESET;
      mask_q <= RESULT_RESET;
    end
    else if (state_q == SQ_CONV && clk_fall && edge_d == EDGE_HOLD)
    begin
      approximation_register_q <= TRIAL_MSB;
      mask_q <= TRIAL_MSB;
    end
    else if (decide)
    begin
      // comparator high keeps the bit; its half LSB offset sets code edges
      approximation_register_q <= (comp_s ? approximation_register_q
        : (approximation_register_q & ~mask_q)) | (mask_q >> 1);
      mask_q <= mask_q >> 1;
    end
  end

  // -------------------------------------------------------------------
  // result latch, binary code in either input mode
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      result_q <= RESULT_RESET;
    end
    else if (state_q == SQ_CONV && clk_fall && edge_d == EDGE_DONE)
    begin
      // unipolar: straight binary; bipolar: offset binary, same bits
      result_q <= approximation_register_q;
    end
  end

  // -------------------------------------------------------------------
  // host data bus drive
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bus_q <= '{data: RESULT_RESET, oe: 1'b0};
    end
    else
    begin
      bus_q.oe <= req;
      bus_q.data <= result_q;
    end
  end

endmodule

// file: testbench/sarseq_asserts.sv
// Purpose: port timing checks for the conversion sequencer
// Assumes: pin clock slow against clk_sys
// Notes: bound into sarseq_top
`timescale 1ns/1ps
module sarseq_asserts
  import sarseq_pkg::*;
#(
  parameter int RBITS = RESULT_BITS
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // sequencer outputs and the clock select pin
  input wire logic ext_clk_sel,
  input wire logic osc_run_q,
  input wire logic div_clk_q,
  input wire logic busy_n_q,
  input wire logic hold_q,
  input wire sarseq_bus_t bus_q,
  input wire logic [RBITS-1:0] approximation_register_q,
  input wire logic [RBITS-1:0] result_q
);
  logic div_prev_q;
  logic [4:0] tgl_q;

  // divided clock changes counted during a conversion
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      div_prev_q <= 1'b0;
      tgl_q <= 5'h00;
    end
    else
    begin
      div_prev_q <= div_clk_q;
      tgl_q <= busy_n_q ? 5'h00 : tgl_q + 5'(div_clk_q != div_prev_q);
    end
  end

  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // sequences and assertions
  // ---------------------------------------------------------------
  sequence s_done;
    $rose(busy_n_q);
  endsequence
  sequence s_idle;
    busy_n_q && $past(busy_n_q);
  endsequence

  a_conv_length: assert property (s_done |-> tgl_q == 5'h13)
    else $error("conversion not twenty pin edges");
  a_hold_third: assert property ($rose(hold_q) |-> tgl_q == 5'h02)
    else $error("hold not on third pin edge");
  a_clear_first: assert property ($rose(hold_q) |->
    $past(approximation_register_q) == 8'h00)
    else $error("register not cleared before trials");
  a_done_clean: assert property (s_done |->
    !hold_q && !div_clk_q && !osc_run_q)
    else $error("clocks or hold left on at end");
  a_idle_gated: assert property (s_idle |-> !div_clk_q && !hold_q)
    else $error("divided clock runs while idle");
  a_result_held: assert property (!$rose(busy_n_q) |-> $stable(result_q))
    else $error("result changed outside completion");
  a_bus_copy: assert property (1'b1 |=> bus_q.data == $past(result_q))
    else $error("bus data not result copy");
  a_osc_own: assert property (osc_run_q && $past(osc_run_q) |->
    !ext_clk_sel && !busy_n_q)
    else $error("own oscillator runs when not wanted");
endmodule

bind sarseq_top sarseq_asserts #(.RBITS(RBITS)) chk_i
(
  .clk_sys(clk_sys), .rst(rst), .ext_clk_sel(ext_clk_sel),
  .osc_run_q(osc_run_q), .div_clk_q(div_clk_q), .busy_n_q(busy_n_q),
  .hold_q(hold_q), .bus_q(bus_q), .result_q(result_q),
  .approximation_register_q(approximation_register_q)
);

// file: testbench/sarseq_far.sv
// Purpose: host strobes, pin clock and comparator model
// Assumes: pin clock of 1 MHz from a 10 MHz clk_sys
// Notes: strobes follow req from the bench
`timescale 1ns/1ps
module sarseq_far
#(
  parameter int HALF = 5
)
(
  // clock
  input wire logic clk_sys,
  // control from the bench; osc_run and trial come from the block
  input wire logic req,
  input wire logic ext_run,
  input wire logic osc_run,
  input wire logic [7:0] code,
  input wire logic [7:0] trial,
  // towards the block
  output logic cs_n,
  output logic rd_n,
  output logic pin,
  output logic comp
);
  int cnt = 0;
  logic pin_q = 1'b0;

  assign pin = pin_q;

  // both strobes low together while req is held
  assign cs_n = !req;
  assign rd_n = !req;
  // bit kept while the input is at or above the trial code
  assign comp = code >= trial;

  // slow pin clock, free running when external, else only when enabled
  always @(posedge clk_sys)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (!ext_run && !osc_run)
      pin_q <= 1'b0;
    else if (cnt == HALF - 1)
      pin_q <= !pin_q;
  end
endmodule

// file: testbench/sarseq_tb.sv
// Purpose: self-checking bench for the conversion sequencer
// Assumes: 1 MHz pin clock, inputs moved 10 ns after clk_sys rises
// Notes: one task for each scenario
`timescale 1ns/1ps
module sarseq_tb
  import sarseq_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ext_clk_sel = 1'b1;
  logic req = 1'b0;
  logic [7:0] code = 8'h00;
  logic conv_clk_pin, osc_run_q, div_clk_q, cs_n, rd_n, busy_n_q;
  logic comp_in, hold_q;
  logic [7:0] appr_reg, result_q;
  sarseq_bus_t bus_q;
  int miscompares = 0;
  int n_tests = 0;

  always #50 clk_sys = !clk_sys;

  sarseq_top dut
  (
    .clk_sys(clk_sys), .rst(rst), .conv_clk_pin(conv_clk_pin),
    .ext_clk_sel(ext_clk_sel), .osc_run_q(osc_run_q),
    .div_clk_q(div_clk_q), .cs_n(cs_n), .rd_n(rd_n),
    .busy_n_q(busy_n_q), .bus_q(bus_q), .comp_in(comp_in),
    .hold_q(hold_q), .approximation_register_q(appr_reg), .result_q(result_q)
  );

  sarseq_far host
  (
    .clk_sys(clk_sys), .req(req), .ext_run(ext_clk_sel),
    .osc_run(osc_run_q), .code(code), .trial(appr_reg), .cs_n(cs_n),
    .rd_n(rd_n), .pin(conv_clk_pin), .comp(comp_in)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, lo, hi, input string what);
    n_tests++;
    if (got < lo || got > hi)
    begin
      miscompares++;
      $display("MISMATCH %0t %s out of range %0d", $time, what, got);
    end
  endtask

  // bounded wait for the busy level, cycles counted in n
  task automatic wait_busy(input logic lvl, output int n);
    n = 0;
    while (busy_n_q !== lvl && n < 2000)
    begin
      tick(1);
      n++;
    end
    if (busy_n_q !== lvl)
    begin
      $display("MISMATCH %0t busy wait ran out", $time);
      miscompares++;
      test_done();
    end
  endtask

  // one conversion with strobes held, then a read of the result
  task automatic convert(input logic [7:0] v, output int len);
    int n;
    code = v;
    req = 1'b1;
    wait_busy(1'b0, n);
    wait_busy(1'b1, len);
    tick(2);
    chk(result_q, v, "result");
    chk(appr_reg, v, "register");
    chk(bus_q.data, v, "bus data");
    chk({7'h00, bus_q.oe}, 8'h01, "bus drive");
    chk({7'h00, hold_q}, 8'h00, "hold released");
    req = 1'b0;
    tick(30);
    chk({7'h00, bus_q.oe}, 8'h00, "bus released");
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_codes();
    logic [7:0] tbl [6] = '{8'h00, 8'h01, 8'h7F, 8'h80, 8'hFE, 8'hFF};
    int len;
    foreach (tbl[i])
    begin
      convert(tbl[i], len);
      chk_rng(len, 191, 200, "busy length");
      chk({7'h00, div_clk_q}, 8'h00, "idle divider");
    end
    $display("codes test done");
  endtask

  task automatic t_restart();
    int n;
    int len;
    code = 8'h3C;
    req = 1'b1;
    wait_busy(1'b0, n);
    tick(50);
    chk(bus_q.data, 8'hFF, "old data");
    chk({7'h00, hold_q}, 8'h01, "input held");
    req = 1'b0;
    tick(5);
    req = 1'b1;
    wait_busy(1'b1, len);
    chk_rng(len + 55, 191, 200, "no restart");
    tick(2);
    chk(result_q, 8'h3C, "restart result");
    // strobe again well inside one pin clock period of completion
    req = 1'b0;
    tick(1);
    req = 1'b1;
    tick(30);
    chk({7'h00, busy_n_q}, 8'h01, "skip window");
    req = 1'b0;
    tick(30);
    $display("restart test done");
  endtask

  // own oscillator: two conversions back to back, clock stops after each
  task automatic t_own_osc();
    logic [7:0] v;
    int len;
    v = 8'hA5;
    ext_clk_sel = 1'b0;
    tick(20);
    repeat (2)
    begin
      convert(v, len);
      chk_rng(len, 199, 203, "own osc length");
      chk({6'h00, osc_run_q, conv_clk_pin}, 8'h00, "osc stopped");
      v = ~v;
    end
    $display("own oscillator test done");
  endtask

  initial
  begin
    tick(3);
    rst = 1'b0;
    tick(2);
    t_codes();
    t_restart();
    t_own_osc();
    test_done();
  end
endmodule
